// file: design/pgx_pkg.sv
// constants shared by the port 3 gpio and external interrupt block
`default_nettype none

package pgx_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NPIN  = 7;   // pins on this port
  localparam int unsigned NLINE = 8;   // external interrupt lines

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PEND = 8'hE7;  // ext_irq_pending
  localparam logic [7:0] OFF_CFGH = 8'hE8;  // ext_irq_edge_cfg_high
  localparam logic [7:0] OFF_CFGL = 8'hE9;  // ext_irq_edge_cfg_low
  localparam logic [7:0] OFF_CONH = 8'hEA;  // pin_function_high
  localparam logic [7:0] OFF_CONL = 8'hEB;  // pin_function_low
  localparam logic [7:0] OFF_PUR  = 8'hEC;  // pullup_enable
  localparam logic [7:0] OFF_PNE  = 8'hED;  // open_drain_select
  localparam logic [7:0] OFF_DATA = 8'hF3;  // port_pin_data

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;  // all registers
  localparam logic [1:0] RST_WARM = 2'h0;   // detector warm-up start

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FN_IN   = 2'h0;  // schmitt input
  localparam logic [1:0] FN_OUT  = 2'h1;  // port output
  localparam logic [1:0] FN_ALT  = 2'h2;  // shared peripheral
  localparam logic [1:0] FN_SEG  = 2'h3;  // lcd segment
  localparam logic [1:0] EG_OFF  = 2'h0;  // line disabled
  localparam logic [1:0] EG_FALL = 2'h1;  // falling edge
  localparam logic [1:0] EG_RISE = 2'h2;  // rising edge
  localparam logic [1:0] EG_BOTH = 2'h3;  // both edges

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [1:0] WARM_DONE = 2'h3;  // cycles before detect

endpackage

`default_nettype wire

// file: design/pgx_port3.sv
// port 3 gpio with pin functions and external interrupt lines
// Operation
// - reset clears both pin-function registers, every pin starts input.
// - pins 6,5 codes: input+interrupt+timer, output, none, lcd segment.
// - pin 4 codes: input+interrupt, output, timer output or pwm, segment.
// - pin 2 codes: input+interrupt, output, uart0 transmit, segment.
// - pin 1 codes: input+interrupt+uart0 rx, output, receive out, segment.
// - pins 3,0 codes: input+interrupt, output, none, lcd segment.
// - edge field: 00 off, 01 falling, 10 rising, 11 both.
// - high edge register: [7:6] port0 pin3, lower fields pins 2,1,0.
// - enabled selected edge sets its pending flag and lowers the request.
// - writing 0 clears a pending flag; software clears after acknowledge.
// - pending flag reads 1 while the line's request is outstanding.
// - pending bits: 7 port0 pin3, 6..4 pins 2..0, 3..0 pins 6..3.
// - pull-up bits 0..6 enable per-pin pull-up; bit 7 reserved.
// - pull-up forced off for push-pull output or shared function.
// - open-drain bits 0..6 select open-drain when set; bit 7 reserved.
// - data register writes output levels and reads pin levels.
// - low edge register fields 7:6..1:0 serve pins 6..3, reset zero.
`default_nettype none

module pgx_port3
  import pgx_pkg::*;
(
  input  wire logic       MCLK,        // system clock, 250 mhz
  input  wire logic       SYS_RST,     // sync reset, active high
  input  wire logic [7:0] REG_ADDR,    // register address
  input  wire logic       REG_WR,      // write strobe
  input  wire logic       REG_RD,      // read strobe
  input  wire logic [7:0] REG_WDATA,   // write data
  output var  logic [7:0] REG_RDATA,   // read data, next cycle
  input  wire logic [6:0] PIN_I,       // pin levels
  output var  logic [6:0] PIN_O,       // pin drive value
  output var  logic [6:0] PIN_OE,      // pin drive enable
  output var  logic [6:0] PIN_PU,      // pull-up on
  input  wire logic       P03_I,       // neighbour port0 pin3
  input  wire logic       TA_OUT_I,    // timer a output or pwm
  input  wire logic       UART_TX_I,   // uart0 transmit data
  input  wire logic       UART_RXO_I,  // uart0 receive line outward
  input  wire logic [6:0] LCD_SEG_I,   // lcd segment drive per pin
  output var  logic       TA_CAP_O,    // timer a capture in
  output var  logic       TA_CLK_O,    // timer a clock in
  output var  logic       UART_RX_O,   // uart0 receive in
  output var  logic       IRQ_N        // interrupt request, low
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] con_l;  // pin_function_low
    logic [5:0] con_h;  // pin_function_high
    logic [7:0] cfg_h;  // ext_irq_edge_cfg_high
    logic [7:0] cfg_l;  // ext_irq_edge_cfg_low
    logic [7:0] pend;   // ext_irq_pending
    logic [6:0] pur;    // pullup_enable
    logic [6:0] pne;    // open_drain_select
    logic [6:0] dout;   // port_pin_data output latch
    logic [7:0] s1;     // sync stage one, line order
    logic [7:0] s2;     // sync stage two
    logic [7:0] prv;    // previous level for edges
    logic [1:0] warm;   // detector warm-up
    logic [7:0] rdata;  // read data
    logic [6:0] pin_o;  // pin value
    logic [6:0] pin_oe; // pin enable
    logic [6:0] pin_pu; // pull-up
    logic       irq_n;  // request to cpu
  } pgx_state_s;

  pgx_state_s st_r;
  pgx_state_s st_nxt;

  logic [13:0] fn_all;  // two bits per pin
  logic [15:0] cfg_all; // two bits per line
  logic [6:0]  pin_s;   // synced pins, pin order
  logic [7:0]  set_v;   // edges seen this cycle
  logic [7:0]  clr_v;   // flags cleared by software
  logic        wr_pend; // pending register write

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address match, used only by the pending-register write decode
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] o);
    return a == o;
  endfunction

  // edge qualifier for one line
  function automatic logic edge_hit(input logic [1:0] c,
                                    input logic       p,
                                    input logic       q);
    logic r;
    r = 1'b0;
    unique case (c)
      EG_OFF:  r = 1'b0;
      EG_FALL: r = p & ~q;
      EG_RISE: r = ~p & q;
      EG_BOTH: r = p ^ q;
    endcase
    return r;
  endfunction

  // {drive, value} for pin i before open-drain shaping
  function automatic logic [1:0] pin_drv(input int unsigned i,
                                         input logic [1:0]  fn,
                                         input logic        d,
                                         input logic        seg);
    logic [1:0] r;
    r = 2'h0;
    unique case (fn)
      FN_IN:  r = 2'h0;
      FN_OUT: r = {1'b1, d};
      FN_ALT: begin
        // pins without a shared function stay undriven
        if (i == 4) r = {1'b1, TA_OUT_I};
        else if (i == 2) r = {1'b1, UART_TX_I};
        else if (i == 1) r = {1'b1, UART_RXO_I};
        else r = 2'h0;
      end
      FN_SEG: r = {1'b1, seg};
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  // pin i uses bits [2i+1:2i]; line k uses cfg bits [2k+1:2k]
  assign fn_all  = {st_r.con_h, st_r.con_l};
  assign cfg_all = {st_r.cfg_h, st_r.cfg_l};
  // lines 0..3 are pins 3..6, 4..6 pins 0..2, 7 port0 pin3
  assign pin_s   = {st_r.s2[3:0], st_r.s2[6:4]};
  assign wr_pend = REG_WR & hit(REG_ADDR, OFF_PEND);
  assign clr_v   = wr_pend ? ~REG_WDATA : 8'h00;

  // edge detect runs on the second sync stage only
  genvar gk;
  generate
    for (gk = 0; gk < NLINE; gk++) begin : g_line
      assign set_v[gk] = (st_r.warm == WARM_DONE) &&
                         edge_hit(cfg_all[2*gk +: 2],
                                  st_r.prv[gk],
                                  st_r.s2[gk]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // pin sampling; warm-up hides the false edge after reset
    st_nxt.s1  = {P03_I, PIN_I[2:0], PIN_I[6:3]};
    st_nxt.s2  = st_r.s1;
    st_nxt.prv = st_r.s2;
    if (st_r.warm != WARM_DONE) begin
      st_nxt.warm = 2'(st_r.warm + 2'h1);
    end
    // a set in the clearing cycle wins, so no edge is lost
    st_nxt.pend  = (st_r.pend & ~clr_v) | set_v;
    st_nxt.irq_n = ~|st_nxt.pend;
    // register writes; reserved bits are not stored
    if (REG_WR) begin
      unique case (REG_ADDR)
        OFF_CFGH: st_nxt.cfg_h = REG_WDATA;
        OFF_CFGL: st_nxt.cfg_l = REG_WDATA;
        OFF_CONH: st_nxt.con_h = REG_WDATA[5:0];
        OFF_CONL: st_nxt.con_l = REG_WDATA;
        OFF_PUR:  st_nxt.pur   = REG_WDATA[6:0];
        OFF_PNE:  st_nxt.pne   = REG_WDATA[6:0];
        OFF_DATA: st_nxt.dout  = REG_WDATA[6:0];
        default:  st_nxt.dout  = st_r.dout;
      endcase
    end
    // reads return state one cycle later; unmapped read zero
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFF_PEND: st_nxt.rdata = st_r.pend;
        OFF_CFGH: st_nxt.rdata = st_r.cfg_h;
        OFF_CFGL: st_nxt.rdata = st_r.cfg_l;
        OFF_CONH: st_nxt.rdata = {2'h0, st_r.con_h};
        OFF_CONL: st_nxt.rdata = st_r.con_l;
        OFF_PUR:  st_nxt.rdata = {1'b0, st_r.pur};
        OFF_PNE:  st_nxt.rdata = {1'b0, st_r.pne};
        OFF_DATA: st_nxt.rdata = {1'b0, pin_s};
        default:  st_nxt.rdata = RST_BYTE;
      endcase
    end
    // pin drive, open-drain shaping and pull-up gating
    for (int unsigned i = 0; i < NPIN; i++) begin
      logic [1:0] dv;
      logic [1:0] fn;
      fn = fn_all[2*i +: 2];
      dv = pin_drv(i, fn, st_r.dout[i], LCD_SEG_I[i]);
      // open drain only pulls low
      st_nxt.pin_oe[i] = dv[1] & (~st_r.pne[i] | ~dv[0]);
      st_nxt.pin_o[i]  = dv[0] & ~st_r.pne[i];
      // pull-up kept for input and open-drain output only
      st_nxt.pin_pu[i] = st_r.pur[i] &
                         ((fn == FN_IN) |
                          ((fn == FN_OUT) & st_r.pne[i]));
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_r <= '{con_l:  RST_BYTE,
                con_h:  RST_BYTE[5:0],
                cfg_h:  RST_BYTE,
                cfg_l:  RST_BYTE,
                pend:   RST_BYTE,
                pur:    RST_BYTE[6:0],
                pne:    RST_BYTE[6:0],
                dout:   RST_BYTE[6:0],
                s1:     RST_BYTE,
                s2:     RST_BYTE,
                prv:    RST_BYTE,
                warm:   RST_WARM,
                rdata:  RST_BYTE,
                pin_o:  RST_BYTE[6:0],
                pin_oe: RST_BYTE[6:0],
                pin_pu: RST_BYTE[6:0],
                irq_n:  1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // all straight from flip-flops
  assign REG_RDATA = st_r.rdata;
  assign PIN_O     = st_r.pin_o;
  assign PIN_OE    = st_r.pin_oe;
  assign PIN_PU    = st_r.pin_pu;
  assign IRQ_N     = st_r.irq_n;
  // peripheral inputs see synced pins; enabling is peripheral's job
  assign TA_CAP_O  = st_r.s2[3];  // pin 6
  assign TA_CLK_O  = st_r.s2[2];  // pin 5
  assign UART_RX_O = st_r.s2[5];  // pin 1

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_reset_func: assert property (
    disable iff (1'b0)
    SYS_RST |=> (st_r.con_l == 8'h00) && (st_r.con_h == 6'h00)
              && (PIN_OE == 7'h00) && IRQ_N)
    else $error("pin function not cleared by reset");

  a_fall_line0: assert property (
    (st_r.warm == WARM_DONE) && (st_r.cfg_l[1:0] == EG_FALL)
    && st_r.prv[0] && !st_r.s2[0]
    |=> st_r.pend[0] ##0 !IRQ_N)
    else $error("falling edge on pin 3 did not set flag");

  a_line7_off: assert property (
    (st_r.cfg_h[7:6] == EG_OFF) && !st_r.pend[7] |=> !st_r.pend[7])
    else $error("disabled port0 line set its flag");

  a_flag_clear: assert property (
    wr_pend && (REG_WDATA == 8'h00) && (set_v == 8'h00)
    |=> (st_r.pend == 8'h00) && IRQ_N)
    else $error("write of zero did not clear flags");

  a_irq_hold: assert property (
    (|st_r.pend) |-> !IRQ_N)
    else $error("request released with a flag set");

  a_pend_read: assert property (
    REG_RD && (REG_ADDR == OFF_PEND)
    |=> REG_RDATA == $past(st_r.pend))
    else $error("pending read mismatch");

  a_pin_read: assert property (
    REG_RD && (REG_ADDR == OFF_DATA)
    |=> REG_RDATA == {1'b0, $past(st_r.s2[3:0]),
                      $past(st_r.s2[6:4])})
    else $error("data read does not show pins");

  a_pullup_off: assert property (
    (st_r.con_l[1:0] == FN_OUT) && !st_r.pne[0] |=> !PIN_PU[0])
    else $error("pull-up left on for push-pull output");

  a_open_drain: assert property (
    (st_r.con_l[1:0] == FN_OUT) && st_r.pne[0] && st_r.dout[0]
    |=> !PIN_OE[0])
    else $error("open-drain pin drove high");

  a_timer_pwm: assert property (
    (st_r.con_h[1:0] == FN_ALT) && !st_r.pne[4]
    |=> PIN_OE[4] && (PIN_O[4] == $past(TA_OUT_I)))
    else $error("pin 4 not driven by timer output");

  // a pin that really moves again may set again; only a steady pin may not
  a_edge_once: assert property (
    set_v[1] ##1 $stable(st_r.s2[1]) |-> !set_v[1])
    else $error("one edge counted twice");

  // the set must survive a clear written in the same cycle
  a_set_wins: assert property (
    (set_v != 8'h00)
    |=> ((st_r.pend & $past(set_v)) == $past(set_v)) && !IRQ_N)
    else $error("edge did not set its pending flag");

  a_irq_release: assert property (
    (st_r.pend == 8'h00) |-> IRQ_N)
    else $error("request held with no flag set");

  a_uart_tx: assert property (
    (st_r.con_l[5:4] == FN_ALT) && !st_r.pne[2]
    |=> PIN_OE[2] && (PIN_O[2] == $past(UART_TX_I)))
    else $error("pin 2 not driven by uart0 transmit");

  a_rx_out: assert property (
    (st_r.con_l[3:2] == FN_ALT) && !st_r.pne[1]
    |=> PIN_OE[1] && (PIN_O[1] == $past(UART_RXO_I)))
    else $error("pin 1 not driven by receive line");

  // code 10 on pins without a shared function leaves them alone
  a_no_alt: assert property (
    (st_r.con_h[5:4] == FN_ALT) && (st_r.con_l[1:0] == FN_ALT)
    |=> !PIN_OE[6] && !PIN_OE[0] && !PIN_PU[6] && !PIN_PU[0])
    else $error("unavailable code drove a pin");

  a_seg_drive: assert property (
    (st_r.con_h[3:2] == FN_SEG) && !st_r.pne[5]
    |=> PIN_OE[5] && (PIN_O[5] == $past(LCD_SEG_I[5])))
    else $error("pin 5 not driven by its segment");

  a_rsv_read: assert property (
    REG_RD && ((REG_ADDR == OFF_PUR) || (REG_ADDR == OFF_PNE))
    |=> !REG_RDATA[7])
    else $error("reserved bit read as one");

  c_rise_line7: cover property (
    (st_r.cfg_h[7:6] == EG_RISE) ##1 st_r.pend[7]);
  c_set_clear: cover property (wr_pend && (set_v != 8'h00));
  c_irq_cycle: cover property (!IRQ_N ##[1:20] IRQ_N);
  c_both_edge: cover property (
    (st_r.cfg_l[7:6] == EG_BOTH) && set_v[3]);
  c_open_low: cover property (st_r.pne[1] && PIN_OE[1] && !PIN_O[1]);

endmodule

`default_nettype wire

// file: dv/pgx_pin_model.sv
// model of the external wires on the seven port pins
`default_nettype none

module pgx_pin_model (
  input  wire logic [0:0] MCLK,    // system clock
  input  wire logic [6:0] PIN_O,   // design drive value
  input  wire logic [6:0] PIN_OE,  // design drive enable
  input  wire logic [6:0] PIN_PU,  // design pull-up on
  input  wire logic [6:0] EXT_V,   // external driver value
  input  wire logic [6:0] EXT_EN,  // external driver on
  output var  logic [6:0] PIN_LVL  // resolved wire level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [6:0] last_r = 7'h00;  // level seen at the last edge

  // a floating pin without pull-up flips every cycle, so a design
  // that reads an undriven wire cannot pass by luck
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (PIN_OE[i]) PIN_LVL[i] = PIN_O[i];
      else if (EXT_EN[i]) PIN_LVL[i] = EXT_V[i];
      else if (PIN_PU[i]) PIN_LVL[i] = 1'b1;
      else PIN_LVL[i] = ~last_r[i];
    end
  end

  // remember the level for the floating case
  always_ff @(posedge MCLK) last_r <= PIN_LVL;
endmodule

`default_nettype wire

// file: dv/port3_gpio_ext_interrupts_tb_top.sv
// self-checking bench for the port 3 gpio and external interrupts
`default_nettype none

module port3_gpio_ext_interrupts_tb_top;
  import pgx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, a) chk(n, 8'(e), 8'(a))

  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic       MCLK = 1'b0;
  logic       SYS_RST = 1'b1;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic       REG_WR = 1'b0;
  logic       REG_RD = 1'b0;
  logic       P03_I = 1'b1;
  logic [6:0] ext_v = 7'h7F;
  logic [6:0] ext_en = 7'h7F;
  // peripherals stand enabled; the timer level moves in the pin test
  logic       TA_OUT_I = 1'b1;
  logic       UART_TX_I = 1'b0;
  logic       UART_RXO_I = 1'b1;
  logic [6:0] LCD_SEG_I = 7'h2A;
  logic [7:0] REG_RDATA;
  logic [6:0] PIN_I, PIN_O, PIN_OE, PIN_PU;
  logic       TA_CAP_O, TA_CLK_O, UART_RX_O, IRQ_N;
  int         failures = 0;
  int         checked = 0;
  int         cyc = 0;

  pgx_port3 pgx_port3_i (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .PIN_I(PIN_I), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .PIN_PU(PIN_PU), .P03_I(P03_I),
    .TA_OUT_I(TA_OUT_I), .UART_TX_I(UART_TX_I),
    .UART_RXO_I(UART_RXO_I), .LCD_SEG_I(LCD_SEG_I),
    .TA_CAP_O(TA_CAP_O), .TA_CLK_O(TA_CLK_O),
    .UART_RX_O(UART_RX_O), .IRQ_N(IRQ_N));

  pgx_pin_model pgx_pin_model_i (
    .MCLK(MCLK), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .PIN_PU(PIN_PU),
    .EXT_V(ext_v), .EXT_EN(ext_en), .PIN_LVL(PIN_I));

  // clock, and a ceiling well above the 1400 or so cycles needed
  always #2 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(string n, logic [7:0] e, logic [7:0] a);
    checked++;
    if (a !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, a);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cycles(int n);
    repeat (n) @(negedge MCLK);
  endtask

  // strobes last one cycle; the next access waits a fresh edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge MCLK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge MCLK);
    REG_WR = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(negedge MCLK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge MCLK);
    REG_RD = 1'b0;
    d = REG_RDATA;
  endtask

  // pending bit b: 0..3 pins 3..6, 4..6 pins 0..2, 7 neighbour pin
  task automatic set_line(int b, logic v);
    @(negedge MCLK);
    if (b == 7) P03_I = v;
    else ext_v[b < 4 ? b + 3 : b - 4] = v;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] a[8] = '{OFF_PEND, OFF_CFGH, OFF_CFGL, OFF_CONH,
                         OFF_CONL, OFF_PUR, OFF_PNE, 8'hE0};
    logic [7:0] e[8] = '{8'h00, 8'hFF, 8'hFF, 8'h3F,
                         8'hFF, 8'h7F, 8'h7F, 8'h00};
    logic [7:0] d;
    `CHK("request idle", 1, IRQ_N);
    for (int i = 0; i < 8; i++) begin
      rd(a[i], d);
      `CHK("reset value", 0, d);
      wr(a[i], 8'hFF);
      rd(a[i], d);
      `CHK("readback", e[i], d);
      wr(a[i], 8'h00);
    end
  endtask

  task automatic t_edges();
    logic [15:0] cfg;
    logic [7:0]  d, ex;
    for (int b = 0; b < 8; b++) begin
      for (int m = 0; m < 4; m++) begin
        cfg = 16'(m) << (2 * b);
        wr(OFF_CFGL, cfg[7:0]);
        wr(OFF_CFGH, cfg[15:8]);
        // k 0 falls from high, k 1 rises back
        for (int k = 0; k < 2; k++) begin
          set_line(b, 1'(k));
          cycles(6);
          ex = m[k] ? 8'(1 << b) : 8'h00;
          rd(OFF_PEND, d);
          `CHK("pending", ex, d);
          `CHK("request", ~|ex, IRQ_N);
          wr(OFF_PEND, 8'h00);
          cycles(3);
          rd(OFF_PEND, d);
          `CHK("pending cleared", 0, d);
          `CHK("request released", 1, IRQ_N);
        end
      end
    end
  endtask

  task automatic t_clear();
    logic [7:0] d;
    wr(OFF_CFGL, 8'h01);
    wr(OFF_CFGH, 8'h40);
    @(negedge MCLK);
    ext_v[3] = 1'b0;
    P03_I = 1'b0;
    cycles(6);
    rd(OFF_PEND, d);
    `CHK("two pending", 8'h81, d);
    wr(OFF_PEND, 8'h7F);
    rd(OFF_PEND, d);
    `CHK("one cleared", 8'h01, d);
    `CHK("request held", 0, IRQ_N);
    wr(OFF_CFGL, 8'h00);
    wr(OFF_CFGH, 8'h00);
    set_line(0, 1'b1);
    set_line(7, 1'b1);
    wr(OFF_PEND, 8'h00);
  endtask

  task automatic t_pins();
    logic [6:0] oe, o, pu, dat, pur;
    logic [7:0] d;
    logic       v, drv;
    logic [2:0] per;
    dat = 7'h55;
    pur = 7'h5A;
    for (int c = 0; c < 4; c++) begin
      for (int od = 0; od < 2; od++) begin
        @(negedge MCLK);
        ext_en = (c == 0) ? 7'h7F : 7'h00;
        ext_v = 7'h2B;
        // timer level differs from the receive line in push-pull
        TA_OUT_I = 1'(od);
        wr(OFF_PUR, {1'b0, pur});
        wr(OFF_PNE, od ? 8'h7F : 8'h00);
        wr(OFF_DATA, {1'b0, dat});
        wr(OFF_CONL, {4{2'(c)}});
        wr(OFF_CONH, {2'b00, {3{2'(c)}}});
        cycles(4);
        for (int i = 0; i < 7; i++) begin
          drv = c != 0 && (c != 2 || i == 1 || i == 2 || i == 4);
          v = c == 1 ? dat[i] : c == 3 ? LCD_SEG_I[i] :
              i == 4 ? TA_OUT_I : i == 2 ? UART_TX_I : UART_RXO_I;
          oe[i] = drv && !(od != 0 && v);
          o[i] = drv && od == 0 && v;
          pu[i] = pur[i] && (c == 0 || (c == 1 && od != 0));
        end
        `CHK("drive enable", oe, PIN_OE);
        `CHK("drive value", o, PIN_O & PIN_OE);
        `CHK("pull-up", pu, PIN_PU);
        if (c == 0) begin
          per = {TA_CAP_O, TA_CLK_O, UART_RX_O};
          `CHK("periph in", 3'h3, per);
          rd(OFF_DATA, d);
          `CHK("pin read", 8'h2B, d);
        end
        if (c == 1 && od == 0) begin
          rd(OFF_DATA, d);
          `CHK("output read", 8'h55, d);
        end
      end
    end
    @(negedge MCLK);
    ext_en = 7'h7F;
    ext_v = 7'h7F;
    wr(OFF_CONL, 8'h00);
    wr(OFF_CONH, 8'h00);
    cycles(4);
    wr(OFF_PEND, 8'h00);
  endtask

  // --------------------------------------------------------------
  // sequence: reset, then wait out the detector warm-up
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(negedge MCLK);
    SYS_RST = 1'b0;
    cycles(6);
    t_regs();
    t_edges();
    t_clear();
    t_pins();
    finish_test();
  end
endmodule

`default_nettype wire
